// file: rtl/rimc_pkg.sv
// Purpose: Shared constants for reset, interrupt and mode control
// Assumes: 10 MHz system clock, machine cycle is clock divided by four
// Notes: Vector helper is used for interrupt fetches; the reset fetch uses VEC_RESET directly
package rimc_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned MC_DIV = 4;
	localparam logic [15:0] IO_CONTROL_ADDR = 16'h0100;
	localparam logic [15:0] SECURITY_LOCK_ADDR = 16'h017f;
	localparam int IOC_EN1 = 0;
	localparam int IOC_FLAG1 = 1;
	localparam int IOC_EN2 = 2;
	localparam int IOC_FLAG2 = 3;
	localparam int IOC_EN3 = 4;
	localparam int IOC_FLAG3 = 5;
	localparam int IOC_MODE_LO = 6;
	localparam int IOC_MODE_HI = 7;
	localparam logic [1:0] MEM_SINGLE = 2'h0;
	localparam logic [1:0] MEM_ILLEGAL = 2'h3;
	localparam int STATUS_GIE = 4;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] SP_INIT = 8'h01;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [7:0] LOCK_VALUE = 8'h81;
	localparam logic [7:0] LOCK_RST = 8'h00;
	localparam logic [4:0] ENTRY_CYC = 5'd19;
	localparam logic [4:0] ENTRY_IDLE_CYC = 5'd17;
	localparam int unsigned BLOCK_CLEAR_MS = 100;
	localparam int unsigned BLOCK_CLEAR_CYC = BLOCK_CLEAR_MS * (CLK_HZ / 1000) / MC_DIV;

	typedef enum logic [2:0] {
		MD_NORMAL,
		MD_MICRO,
		MD_EXT_PROG,
		MD_EXT_VERIFY,
		MD_BLOCK_CLEAR
	} rimc_strap_e;

	// Level 0 is the reset vector; levels 1 to 3 sit just below it, two bytes apart
	function automatic logic [15:0] rimc_vector(input logic [1:0] lvl);
		return VEC_RESET - {13'h0000, lvl, 1'b0};
	endfunction : rimc_vector
endpackage : rimc_pkg

// file: rtl/rimc_sync.sv
// Purpose: Two-flop synchroniser for pins
// Assumes: Inputs are asynchronous to i_clk_sys
// Notes: Only the second stage may be read
`timescale 1ns/1ps
module rimc_sync #(
	parameter int W = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			meta <= '1;
			o_q <= '1;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule : rimc_sync

// file: rtl/rimc_mcdiv.sv
// Purpose: Machine-cycle enable from the system clock
// Assumes: DIV of two or more
// Notes: One-cycle tick every DIV clocks
`timescale 1ns/1ps
module rimc_mcdiv #(
	parameter int DIV = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	output logic o_tick
);
	logic [$clog2(DIV)-1:0] cnt;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt <= (cnt == $bits(cnt)'(DIV - 1)) ? '0 : cnt + 1'b1;
			o_tick <= (cnt == $bits(cnt)'(DIV - 1));
		end
	end
endmodule : rimc_mcdiv

// file: rtl/rimc_ctrl.sv
// Purpose: Reset, interrupt priority and operating-mode control
// Assumes: CPU core on the same clock drives the peripheral-file and ack strobes
// Notes: Lock and block-clear pass state survive i_rstn, cleared by i_por_n or by the second of two completed block clears
`timescale 1ns/1ps
module rimc_ctrl
	import rimc_pkg::*;
#(
	parameter int BLOCK_CLEAR_CYCLES = BLOCK_CLEAR_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_por_n,
	input wire logic i_ext_irq_high_n,
	input wire logic i_ext_irq_low_n,
	input wire logic i_mode_select_pin,
	input wire logic i_mode_select_hv,
	input wire logic i_input_bit4,
	input wire logic i_input_bit7,
	input wire logic i_port_b_bit2,
	input wire logic i_timer_rollover,
	input wire logic [15:0] i_pf_addr,
	input wire logic i_pf_wr,
	input wire logic i_pf_prg,
	input wire logic [7:0] i_pf_wdata,
	input wire logic i_st_wr,
	input wire logic [7:0] i_st_wdata,
	input wire logic i_return_from_irq,
	input wire logic [7:0] i_return_from_irq_status,
	input wire logic i_instr_done,
	input wire logic i_idle,
	input wire logic i_irq_ack,
	input wire logic [7:0] i_port_b_data,
	input wire logic [7:0] i_portc_dir,
	input wire logic [7:0] i_portd_dir,
	output logic [7:0] o_pf_rdata,
	output logic [7:0] o_status,
	output logic o_irq_req,
	output logic [1:0] o_irq_level,
	output logic [15:0] o_vec_addr,
	output logic o_vec_fetch,
	output logic o_service_start,
	output logic o_init_clear,
	output logic o_save_pc,
	output logic o_sp_load,
	output logic [7:0] o_sp_value,
	output logic o_cpu_run,
	output logic [1:0] o_mem_mode,
	output logic o_prog_pulse,
	output logic o_prog_write,
	output logic o_eeprom_erase,
	output logic o_block_clear_done,
	output logic o_lock,
	output logic [7:0] o_port_b,
	output logic [7:0] o_portc_oe_n,
	output logic [7:0] o_portd_oe_n
);
	typedef enum logic [2:0] {RS_CAPTURE, RS_CLEAR, RS_SAVE, RS_SP, RS_VEC, RS_RUN, RS_HOLD} rimc_rst_e;
	typedef enum logic {IS_WAIT, IS_ENTRY} rimc_irq_e;

	localparam int BCW = $clog2(BLOCK_CLEAR_CYCLES + 1);

	logic [1:0] rst_q;
	logic rst_int_n;
	logic mc_tick;
	logic [6:0] pins_s;
	logic irq1_s, irq3_s, mc_s, hv_s, a4_s, a7_s, b2_s;
	logic irq1_prev, irq3_prev;
	logic [3:1] latch, en, set_ev, clr_ev, flags, pend;
	logic [1:0] best;
	logic ioc_wr;
	rimc_rst_e rst_st;
	rimc_irq_e irq_st;
	rimc_strap_e strap;
	logic [4:0] entry_cnt;
	logic [1:0] srv_level;
	logic [7:0] lock;
	logic bc_pass;
	logic [BCW-1:0] bc_cnt;

	// Reset asserts at once, releases through two flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_int_n = rst_q[1];

	// Pin syncs run on power-on reset so straps are valid at release
	rimc_sync #(.W(7)) u_pin_sync (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_por_n),
		.i_d({i_port_b_bit2, i_input_bit7, i_input_bit4, i_mode_select_hv, i_mode_select_pin,
			i_ext_irq_low_n, i_ext_irq_high_n}),
		.o_q(pins_s)
	);
	assign {b2_s, a7_s, a4_s, hv_s, mc_s, irq3_s, irq1_s} = pins_s;

	rimc_mcdiv #(.DIV(MC_DIV)) u_mcdiv (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.o_tick(mc_tick)
	);

	function automatic logic [1:0] prio(input logic [3:1] p);
		if (p[1]) return 2'd1;
		if (p[2]) return 2'd2;
		if (p[3]) return 2'd3;
		return 2'd0;
	endfunction : prio

	assign ioc_wr = i_pf_wr && (i_pf_addr == IO_CONTROL_ADDR);
	// Falling edge latches a pulse; the sync period covers two oscillator cycles
	assign set_ev = {irq3_prev & ~irq3_s, i_timer_rollover, irq1_prev & ~irq1_s};
	always_comb begin
		clr_ev = '0;
		if (ioc_wr) begin
			clr_ev = {i_pf_wdata[IOC_FLAG3], i_pf_wdata[IOC_FLAG2], i_pf_wdata[IOC_FLAG1]};
		end
		if (i_irq_ack && irq_st == IS_ENTRY) begin
			clr_ev[srv_level] = 1'b1;
		end
	end
	assign flags = latch | {~irq3_s, 1'b0, ~irq1_s};
	assign pend = flags & en & {3{o_status[STATUS_GIE]}};
	assign best = prio(pend);

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			irq1_prev <= 1'b1;
			irq3_prev <= 1'b1;
		end else begin
			irq1_prev <= irq1_s;
			irq3_prev <= irq3_s;
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			latch <= '0;
		end else begin
			latch <= (latch & ~clr_ev) | set_ev;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			en <= '0;
		end else if (rst_st == RS_CLEAR) begin
			en <= '0;
		end else if (ioc_wr) begin
			en <= {i_pf_wdata[IOC_EN3], i_pf_wdata[IOC_EN2], i_pf_wdata[IOC_EN1]};
		end
	end

	// Post-reset sequence, one step per clock
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_st <= RS_CAPTURE;
			strap <= MD_NORMAL;
		end else begin
			unique case (rst_st)
				RS_CAPTURE: begin
					if (rst_int_n) begin
						// Locked part refuses the external EEPROM modes
						if (!mc_s) begin
							strap <= MD_NORMAL;
						end else if (hv_s && b2_s && a4_s && a7_s) begin
							strap <= MD_BLOCK_CLEAR;
						end else if (hv_s && !b2_s && a4_s && !a7_s) begin
							strap <= MD_MICRO;
						end else if (!hv_s && a7_s && lock != LOCK_VALUE) begin
							strap <= a4_s ? MD_EXT_PROG : MD_EXT_VERIFY;
						end else begin
							strap <= MD_NORMAL;
						end
						rst_st <= (mc_s && (hv_s ? (b2_s && a4_s && a7_s) : (a7_s && lock != LOCK_VALUE)))
							? RS_HOLD : RS_CLEAR;
					end
				end
				RS_CLEAR: rst_st <= RS_SAVE;
				RS_SAVE: rst_st <= RS_SP;
				RS_SP: rst_st <= RS_VEC;
				RS_VEC: rst_st <= RS_RUN;
				RS_RUN: rst_st <= RS_RUN;
				RS_HOLD: rst_st <= RS_HOLD;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_init_clear <= 1'b0;
			o_save_pc <= 1'b0;
			o_sp_load <= 1'b0;
			o_sp_value <= SP_INIT;
			o_vec_fetch <= 1'b0;
			o_cpu_run <= 1'b0;
		end else begin
			o_init_clear <= (rst_st == RS_CLEAR);
			o_save_pc <= (rst_st == RS_SAVE);
			o_sp_load <= (rst_st == RS_SP);
			o_sp_value <= SP_INIT;
			o_vec_fetch <= (rst_st == RS_VEC);
			o_cpu_run <= (rst_st == RS_RUN);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_status <= STATUS_RST;
		end else if (rst_st == RS_CLEAR || (i_irq_ack && irq_st == IS_ENTRY)) begin
			o_status <= STATUS_RST;
		end else if (i_return_from_irq) begin
			o_status <= i_return_from_irq_status;
		end else if (i_st_wr) begin
			o_status <= i_st_wdata;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_req <= 1'b0;
			o_irq_level <= 2'd0;
			o_vec_addr <= VEC_RESET;
		end else begin
			o_irq_req <= o_cpu_run && (pend != '0);
			o_irq_level <= best;
			o_vec_addr <= (rst_st == RS_VEC) ? VEC_RESET : rimc_vector(best);
		end
	end

	// Entry latency counted in machine cycles
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_st <= IS_WAIT;
			entry_cnt <= '0;
			srv_level <= 2'd0;
			o_service_start <= 1'b0;
		end else begin
			o_service_start <= 1'b0;
			unique case (irq_st)
				IS_WAIT: begin
					if (o_irq_req && i_instr_done) begin
						irq_st <= IS_ENTRY;
						srv_level <= o_irq_level;
						entry_cnt <= i_idle ? ENTRY_IDLE_CYC : ENTRY_CYC;
					end
				end
				IS_ENTRY: begin
					if (mc_tick) begin
						entry_cnt <= entry_cnt - 5'd1;
						if (entry_cnt == 5'd1) begin
							o_service_start <= 1'b1;
							irq_st <= IS_WAIT;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mem_mode <= MEM_SINGLE;
		end else if (rst_st == RS_CLEAR) begin
			o_mem_mode <= MEM_SINGLE;
		end else if (ioc_wr && strap == MD_NORMAL && lock != LOCK_VALUE
			&& i_pf_wdata[IOC_MODE_HI:IOC_MODE_LO] != MEM_ILLEGAL) begin
			o_mem_mode <= i_pf_wdata[IOC_MODE_HI:IOC_MODE_LO];
		end
	end

	// Lock register: survives i_rstn, removed by a second block clear or by i_por_n
	always_ff @(posedge i_clk_sys or negedge i_por_n) begin
		if (!i_por_n) begin
			lock <= LOCK_RST;
			bc_pass <= 1'b0;
		end else if (i_pf_prg && i_pf_addr == SECURITY_LOCK_ADDR && i_pf_wdata == LOCK_VALUE
			&& o_cpu_run) begin
			lock <= LOCK_VALUE;
		end else if (strap == MD_BLOCK_CLEAR && rst_st == RS_HOLD && mc_tick
			&& bc_cnt == BCW'(BLOCK_CLEAR_CYCLES - 1)) begin
			// A set lock needs a second pass after the memory is gone
			if (lock == LOCK_VALUE && !bc_pass) begin
				bc_pass <= 1'b1;
			end else begin
				lock <= LOCK_RST;
				bc_pass <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			bc_cnt <= '0;
			o_block_clear_done <= 1'b0;
			o_eeprom_erase <= 1'b0;
		end else if (strap == MD_BLOCK_CLEAR && rst_st == RS_HOLD) begin
			o_eeprom_erase <= 1'b1;
			if (mc_tick && !o_block_clear_done) begin
				bc_cnt <= bc_cnt + 1'b1;
				o_block_clear_done <= (bc_cnt == BCW'(BLOCK_CLEAR_CYCLES - 1));
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_prog_pulse <= 1'b0;
			o_prog_write <= 1'b0;
		end else begin
			o_prog_pulse <= (strap == MD_EXT_PROG || strap == MD_EXT_VERIFY) && rst_st == RS_HOLD && a7_s;
			o_prog_write <= strap == MD_EXT_PROG && rst_st == RS_HOLD && a4_s;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_por_n) begin
		if (!i_por_n) begin
			o_lock <= 1'b0;
		end else begin
			o_lock <= (lock == LOCK_VALUE);
		end
	end

	// Ports float and B goes high the moment reset arrives
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_port_b <= 8'hff;
			o_portc_oe_n <= 8'hff;
			o_portd_oe_n <= 8'hff;
		end else begin
			o_port_b <= o_cpu_run ? i_port_b_data : 8'hff;
			o_portc_oe_n <= o_cpu_run ? ~i_portc_dir : 8'hff;
			o_portd_oe_n <= o_cpu_run ? ~i_portd_dir : 8'hff;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pf_rdata <= 8'h00;
		end else if (i_pf_addr == IO_CONTROL_ADDR) begin
			o_pf_rdata <= {o_mem_mode, flags[3], en[3], flags[2], en[2], flags[1], en[1]};
		end else if (i_pf_addr == SECURITY_LOCK_ADDR) begin
			o_pf_rdata <= lock;
		end else begin
			o_pf_rdata <= 8'h00;
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	localparam int E19_MIN = 74;
	localparam int E19_MAX = 77;
	localparam int E17_MIN = 66;
	localparam int E17_MAX = 69;

	sequence s_init_tail;
		o_save_pc ##1 (o_sp_load && o_sp_value == SP_INIT) ##1 (o_vec_fetch && o_vec_addr == VEC_RESET) ##1 o_cpu_run;
	endsequence
	property p_init_seq;
		$rose(o_init_clear) |=> s_init_tail;
	endproperty
	a_init_seq: assert property (p_init_seq) else $error("init sequence broken");

	property p_reset_ports;
		!o_cpu_run |-> ##1 (o_port_b == 8'hff && o_portc_oe_n == 8'hff && o_portd_oe_n == 8'hff);
	endproperty
	a_reset_ports: assert property (p_reset_ports) else $error("ports not safe while held");

	property p_prio;
		pend[1] |=> o_irq_level == 2'd1 && o_vec_addr == 16'hfffc;
	endproperty
	a_prio: assert property (p_prio) else $error("level one not chosen");

	property p_gie_mask;
		!o_status[STATUS_GIE] |=> !o_irq_req;
	endproperty
	a_gie_mask: assert property (p_gie_mask) else $error("request while globally masked");

	property p_clear_w1;
		ioc_wr && i_pf_wdata[IOC_FLAG1] && !set_ev[1] |=> !latch[1];
	endproperty
	a_clear_w1: assert property (p_clear_w1) else $error("flag not cleared");

	property p_set_wins;
		set_ev[2] |=> latch[2];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("timer event lost");

	sequence s_go(logic idl);
		irq_st == IS_WAIT && o_irq_req && i_instr_done && i_idle == idl;
	endsequence
	property p_entry19;
		s_go(1'b0) |-> ##[E19_MIN:E19_MAX] o_service_start;
	endproperty
	a_entry19: assert property (p_entry19) else $error("entry not 19 cycles");

	property p_entry17;
		s_go(1'b1) |-> ##[E17_MIN:E17_MAX] o_service_start;
	endproperty
	a_entry17: assert property (p_entry17) else $error("idle entry not 17 cycles");

	property p_ack;
		i_irq_ack && irq_st == IS_ENTRY && set_ev == '0 |=> o_status == STATUS_RST && !latch[$past(srv_level)];
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear");

	property p_lock_mode;
		o_lock && o_cpu_run && $past(o_cpu_run) |-> $stable(o_mem_mode);
	endproperty
	a_lock_mode: assert property (p_lock_mode) else $error("locked mode changed");
endmodule : rimc_ctrl

// file: tb/rimc_cpu_model.sv
// Purpose: CPU core stand-in that answers interrupt requests
// Assumes: Same clock as the controller
// Notes: i_delay stretches the instruction in progress before the request is taken
`timescale 1ns/1ps
module rimc_cpu_model (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_irq_req,
	input wire logic i_cpu_run,
	input wire logic [3:0] i_delay,
	output logic o_instr_done,
	output logic o_irq_ack
);
	logic [1:0] phase;
	logic [3:0] cnt;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_instr_done <= 1'b0;
			o_irq_ack <= 1'b0;
			phase <= 2'd0;
			cnt <= 4'h0;
		end else begin
			o_instr_done <= 1'b0;
			o_irq_ack <= 1'b0;
			case (phase)
				2'd0: if (i_irq_req && i_cpu_run) begin
					if (cnt == i_delay) begin
						o_instr_done <= 1'b1; // Current instruction ends first
						phase <= 2'd1;
						cnt <= 4'h0;
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
				2'd1: begin
					o_irq_ack <= 1'b1; // Ack after the call is entered
					phase <= 2'd2;
				end
				default: if (!i_irq_req) begin
					phase <= 2'd0; // Wait for the drop so one request is served once
				end
			endcase
		end
	end
endmodule : rimc_cpu_model

// file: tb/rimc_ctrl_bench.sv
// Purpose: Self-checking bench for reset, interrupt and mode control
// Assumes: Block clear shortened to 8 machine ticks
// Notes: Reset is dropped off the clock edge on purpose to show it acts at once
`timescale 1ns/1ps
module rimc_ctrl_bench;
	import rimc_pkg::*;
	logic clk, rstn, por_n, x1_n, x3_n, ms, hv, a4, a7, b2, tmr, wr, eeprom_write_instruction, st_wr, return_from_irq, idle, done, ack;
	logic req, vf, ss, ic, spc, spl, run, pp, pw, er, bcd, lk;
	logic [15:0] addr, vec;
	logic [7:0] wd, st_wd, rt_st, pb, cdir, ddir, rd, st, pbo, coe, doe, spv;
	logic [1:0] lvl, mm, pv;
	logic [3:0] dly;
	int mismatches, checked, n, i;

	rimc_ctrl #(.BLOCK_CLEAR_CYCLES(8)) i_rimc_ctrl (.i_clk_sys(clk), .i_rstn(rstn), .i_por_n(por_n),
		.i_ext_irq_high_n(x1_n), .i_ext_irq_low_n(x3_n), .i_mode_select_pin(ms), .i_mode_select_hv(hv),
		.i_input_bit4(a4), .i_input_bit7(a7), .i_port_b_bit2(b2), .i_timer_rollover(tmr), .i_pf_addr(addr),
		.i_pf_wr(wr), .i_pf_prg(eeprom_write_instruction), .i_pf_wdata(wd), .i_st_wr(st_wr), .i_st_wdata(st_wd), .i_return_from_irq(return_from_irq),
		.i_return_from_irq_status(rt_st), .i_instr_done(done), .i_idle(idle), .i_irq_ack(ack), .i_port_b_data(pb),
		.i_portc_dir(cdir), .i_portd_dir(ddir), .o_pf_rdata(rd), .o_status(st), .o_irq_req(req),
		.o_irq_level(lvl), .o_vec_addr(vec), .o_vec_fetch(vf), .o_service_start(ss), .o_init_clear(ic),
		.o_save_pc(spc), .o_sp_load(spl), .o_sp_value(spv), .o_cpu_run(run), .o_mem_mode(mm),
		.o_prog_pulse(pp), .o_prog_write(pw), .o_eeprom_erase(er), .o_block_clear_done(bcd), .o_lock(lk),
		.o_port_b(pbo), .o_portc_oe_n(coe), .o_portd_oe_n(doe));
	rimc_cpu_model i_rimc_cpu_model (.i_clk_sys(clk), .i_rstn(rstn), .i_irq_req(req), .i_cpu_run(run),
		.i_delay(dly), .o_instr_done(done), .o_irq_ack(ack));

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task automatic pf_wr(input logic [15:0] a, input logic [7:0] d, input logic p);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= ~p;
		eeprom_write_instruction <= p;
		@(posedge clk);
		wr <= 1'b0;
		eeprom_write_instruction <= 1'b0;
		#1;
	endtask : pf_wr

	task automatic pf_rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1;
		cmp(nm, 16'(e), 16'(rd & m));
	endtask : pf_rd

	task automatic wait_on(input int lim, input logic which);
		n = 0;
		while (((which ? ss : done) !== 1'b1) && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_on

	// Straps packed as hv, mode pin, b2, bit4, bit7
	task automatic do_reset(input logic [4:0] s);
		@(negedge clk);
		#10 rstn = 1'b0;
		#5;
		cmp("port_b_async", 16'h00ff, 16'(pbo));
		cmp("portc_oe_async", 16'h00ff, 16'(coe));
		cmp("portd_oe_async", 16'h00ff, 16'(doe));
		{hv, ms, b2, a4, a7} = s;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (50) @(posedge clk);
		n = 0;
		while (bcd !== 1'b1 && s[4] && n < 100) begin
			@(posedge clk);
			n++;
		end
		#1;
	endtask : do_reset

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#2000000;
		mismatches++;
		end_sim();
	end

	initial begin
		{rstn, por_n, ms, hv, a4, a7, b2, tmr, wr, eeprom_write_instruction, st_wr, return_from_irq, idle} = '0;
		{x1_n, x3_n} = 2'b11;
		{addr, wd, st_wd, rt_st, dly} = '0;
		pb = 8'h5a;
		cdir = 8'h0f;
		ddir = 8'hf0;
		mismatches = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		por_n <= 1'b1;
		repeat (18) @(posedge clk);
		cmp("port_b_rst", 16'h00ff, 16'(pbo));
		rstn <= 1'b1;
		for (i = 1; i <= 8; i++) begin
			@(posedge clk);
			#1;
			if (i >= 4) cmp("init_seq", 16'(5'h10 >> (i - 4)), 16'({ic, spc, spl, vf, run}));
			if (i == 7) cmp("reset_vec", VEC_RESET, vec);
		end
		cmp("sp_value", 16'(SP_INIT), 16'(spv));
		cmp("status_init", 16'h0000, 16'(st));
		cmp("mode_strap", 16'h0000, 16'(mm));
		pf_rd(IO_CONTROL_ADDR, 8'h00, 8'hd5, "ioc_init");
		cmp("ports_run", 16'h5af0, {pbo, coe});
		cmp("portd_run", 16'h000f, 16'(doe));
		pf_wr(IO_CONTROL_ADDR, 8'h2a, 1'b0); // Flags undefined at start
		pf_rd(IO_CONTROL_ADDR, 8'h00, 8'hff, "ioc_clear");
		pf_rd(16'h0150, 8'h00, 8'hff, "unmapped");
		for (i = 0; i < 5; i++) begin
			pf_wr(IO_CONTROL_ADDR, {i[1:0], 6'h00}, 1'b0);
			cmp("mem_mode", (i == 3) ? 16'h0002 : 16'(i[1:0]), 16'(mm));
		end
		x3_n <= 1'b0;
		repeat (6) @(posedge clk);
		x3_n <= 1'b1;
		pf_rd(IO_CONTROL_ADDR, 8'h20, 8'h3f, "flag3_masked");
		pf_wr(IO_CONTROL_ADDR, 8'h10, 1'b0);
		pf_rd(IO_CONTROL_ADDR, 8'h30, 8'h3f, "flag3_kept");
		cmp("req_gie_off", 16'h0000, 16'(req));
		pf_wr(IO_CONTROL_ADDR, 8'h35, 1'b0);
		x1_n <= 1'b0;
		x3_n <= 1'b0;
		tmr <= 1'b1;
		@(posedge clk);
		tmr <= 1'b0;
		repeat (5) @(posedge clk);
		{x1_n, x3_n} <= 2'b11;
		pf_rd(IO_CONTROL_ADDR, 8'h3f, 8'h3f, "flags_all");
		cmp("req_masked", 16'h0000, 16'(req));
		st_wr <= 1'b1;
		st_wd <= 8'h10;
		@(posedge clk);
		st_wr <= 1'b0;
		for (i = 1; i < 4; i++) begin
			idle <= (i == 3);
			dly <= (i == 2) ? 4'h5 : 4'h0;
			wait_on(40, 1'b0);
			cmp("irq_level", 16'(i), 16'(lvl));
			cmp("irq_vec", 16'hfffe - 16'(2 * i), vec);
			cmp("irq_vec_top", 16'h0001, 16'(vec >= 16'hffd0));
			wait_on(100, 1'b1);
			cmp("entry_cycles", 16'h0001, 16'(n >= ((i == 3) ? 66 : 74) && n <= ((i == 3) ? 70 : 78)));
			cmp("status_entry", 16'h0000, 16'(st));
			@(posedge clk);
			return_from_irq <= 1'b1;
			rt_st <= 8'h10;
			@(posedge clk);
			return_from_irq <= 1'b0;
			#1;
			cmp("status_return_from_irq", 16'h0010, 16'(st));
		end
		pf_rd(IO_CONTROL_ADDR, 8'h15, 8'h3f, "flags_acked");
		pf_wr(SECURITY_LOCK_ADDR, LOCK_VALUE, 1'b0);
		pf_rd(SECURITY_LOCK_ADDR, 8'h00, 8'hff, "lock_plain_wr");
		cmp("lock_plain_lk", 16'h0000, 16'(lk));
		pf_wr(SECURITY_LOCK_ADDR, LOCK_VALUE, 1'b1);
		pf_rd(SECURITY_LOCK_ADDR, LOCK_VALUE, 8'hff, "lock_reg");
		cmp("lock_prg", 16'h0001, 16'(lk));
		pf_wr(IO_CONTROL_ADDR, 8'h40, 1'b0);
		cmp("mode_locked", 16'h0000, 16'(mm));
		do_reset(5'b11111);
		cmp("clear_pass1", 16'h0007, 16'({er, bcd, lk}));
		do_reset(5'b11111);
		cmp("clear_pass2", 16'h0006, 16'({er, bcd, lk}));
		do_reset(5'b11010);
		pf_wr(IO_CONTROL_ADDR, 8'h40, 1'b0);
		cmp("mode_micro", 16'h0004, 16'({run, mm}));
		do_reset(5'b01001);
		cmp("verify_lines", 16'h0002, 16'({pp, pw}));
		do_reset(5'b01011);
		pv = {pp, pw};
		@(posedge clk);
		a7 <= 1'b0;
		a4 <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		cmp("prog_lines", 16'h0003, 16'(pv ^ {pp, pw}));
		end_sim();
	end
endmodule : rimc_ctrl_bench
